//--- hdl/fcm_pkg.sv
package fcm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS         = 100;
  localparam int UD_STEP1_NS    = 100_000;
  localparam int UD_STEP2_NS    = 200_000;
  localparam int UD_STEP1_CYC   = UD_STEP1_NS / CLK_NS;
  localparam int UD_STEP2_CYC   = UD_STEP2_NS / CLK_NS;
  localparam int SLEEP_TICK_NS  = 100_000_000;
  localparam int SLEEP_TICK_CYC = SLEEP_TICK_NS / CLK_NS;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_OFFS  = 8'h00;
  localparam logic [7:0] A_MODE  = 8'h04;
  localparam logic [7:0] A_TERM  = 8'h08;
  localparam logic [7:0] A_TERM4 = 8'h0c;
  localparam logic [7:0] A_FLASH = 8'h10;
  localparam logic [7:0] A_BAND  = 8'h14;
  localparam logic [7:0] A_SLEEP = 8'h18;
  localparam logic [7:0] A_WAKE  = 8'h1c;
  localparam logic [7:0] A_LVL   = 8'h20;
  localparam logic [7:0] A_FBMB  = 8'h24;
  localparam logic [7:0] A_STAT  = 8'h28;
  localparam logic [7:0] A_OUT   = 8'h2c;
  // ----------------------------------------
  // Mode, sleep and level register fields
  // ----------------------------------------
  localparam int M_SRC  = 0;
  localparam int M_PID  = 8;
  localparam int M_FB   = 16;
  localparam int M_INV  = 24;
  localparam int M_MEM  = 25;
  localparam int M_CLR  = 26;
  localparam int M_AHD  = 27;
  localparam int M_DIR  = 28;
  localparam int SL_DLY = 12;
  localparam int LV_OFF = 10;
  localparam int LV_ON  = 20;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [7:0] FN_SET    = 8'h08;
  localparam logic [7:0] FN_PIDDIS = 8'h17;
  localparam logic [7:0] FN_UP     = 8'h1b;
  localparam logic [7:0] FN_DOWN   = 8'h1c;
  localparam logic [7:0] FN_UDC    = 8'h1d;
  localparam logic [7:0] FN_ADD    = 8'h32;
  localparam logic [7:0] SRC_TERM  = 8'h01;
  localparam logic [7:0] SRC_OPER  = 8'h02;
  localparam logic [7:0] PID_OFF   = 8'h00;
  localparam logic [7:0] PID_ON    = 8'h01;
  localparam logic [7:0] PID_INV   = 8'h02;
  localparam logic [7:0] FB_ANALOG = 8'h01;
  localparam logic [7:0] FB_MODBUS = 8'h02;
  localparam logic [7:0] FB_ARITH  = 8'h0a;
  // ----------------------------------------
  // Limits and reset values
  // ----------------------------------------
  localparam logic [15:0] FREQ_MAX   = 16'h9c40;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  typedef enum logic [1:0] {
    SL_RUN  = 2'b00,
    SL_WAIT = 2'b01,
    SL_OFF  = 2'b10,
    SL_WAKE = 2'b11
  } fcm_sleep_type;
endpackage

//--- hdl/fcm_top.sv
`timescale 1ns/1ns
// What this block does
// [RQ1] While offset input is on, offset (max 400.00 Hz) combines with the command; the code uses all of offs[15:0] with no limit.
// [RQ2] Direction 00 adds the offset, 01 subtracts it.
// [RQ3] Any of five terminal selectors set to 50 becomes the offset trigger.
// [RQ4] Sign change from the offset reverses motor rotation.
// [RQ5] With PID active, offset goes to the PID target in 0.01 percent.
// [RQ6] Code 27 raises, code 28 lowers the frequency while held.
// [RQ7] Code 29 makes a terminal the adjust clear input.
// [RQ8] Raise and lower work with source 02, or source 01 with analog hold.
// [RQ9] Raise and lower ignored on other sources and never touch jogging.
// [RQ10] During raise or lower, code 08 input selects first or second ramp.
// [RQ11] Memory mode 01 keeps setting; mode 00 reverts on undervoltage.
// [RQ12] Clear on wipes the adjusted setting; clear release stores it.
// [RQ13] Clear mode 00 loads zero, 01 loads the power-on stored value.
// [RQ14] Far side must not toggle raise or lower after power is removed.
// [RQ15] PID field 00 off, 01 on, 02 on with negative result inverted.
// [RQ16] Code 23 input disables PID while held.
// [RQ17] Feedback from 01 analog, 02 serial register, 10 arithmetic result.
// [RQ18] Reverse action 01 inverts deviation polarity; 00 leaves it.
// [RQ19] PID output limited to target plus or minus band, 0.0 to 100.0 percent; the code limits only with PID field 01 and a nonzero band.
// [RQ20] Output below sleep threshold stops after delay up to 25.5 s.
// [RQ21] Sleep ends above wake threshold, never below sleep threshold.
// [RQ22] Deviation flag level plus feedback compare off and on levels.
module fcm_top
  import fcm_pkg::*;
#(
  parameter int SLEEP_TICK = SLEEP_TICK_CYC
)(
  input  wire logic               SYS_CLK_I,
  input  wire logic               RST_N_I,
  input  wire logic [7:0]         AXI_AWADDR_I,
  input  wire logic               AXI_AWVALID_I,
  output logic                    AXI_AWREADY_O,
  input  wire logic [31:0]        AXI_WDATA_I,
  input  wire logic [3:0]         AXI_WSTRB_I,
  input  wire logic               AXI_WVALID_I,
  output logic                    AXI_WREADY_O,
  output logic [1:0]              AXI_BRESP_O,
  output logic                    AXI_BVALID_O,
  input  wire logic               AXI_BREADY_I,
  input  wire logic [7:0]         AXI_ARADDR_I,
  input  wire logic               AXI_ARVALID_I,
  output logic                    AXI_ARREADY_O,
  output logic [31:0]             AXI_RDATA_O,
  output logic [1:0]              AXI_RRESP_O,
  output logic                    AXI_RVALID_O,
  input  wire logic               AXI_RREADY_I,
  input  wire logic [4:0]         TERM_I,
  input  wire logic signed [17:0] FREQ_CMD_I,
  input  wire logic               JOG_I,
  input  wire logic               UNDERVOLT_I,
  input  wire logic [15:0]        PID_TARGET_I,
  input  wire logic signed [17:0] PID_RESULT_I,
  input  wire logic [15:0]        FB_ANALOG_I,
  input  wire logic [15:0]        FB_ARITH_I,
  output logic [16:0]             FREQ_O,
  output logic                    REVERSE_O,
  output logic                    RAMP2_O,
  output logic                    UD_ACTIVE_O,
  output logic                    SLEEP_O,
  output logic                    DEV_FLAG_O,
  output logic                    FBV_FLAG_O,
  output logic                    PID_ACTIVE_O
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  logic [31:0] offs, mode, term, term4, flash, band, slp, wake, lvl, fbmb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        aw_ok, w_ok, wr_go, store_ev;
  logic [15:0] adj;
  logic [31:0] stat, outw;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b])
        o[8*b +: 8] = d[8*b +: 8];
    return o;
  endfunction

  assign wr_go = aw_ok && w_ok && !AXI_BVALID_O;

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
    begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      AXI_AWREADY_O <= 1'b1;
      AXI_WREADY_O <= 1'b1;
      awaddr <= 8'h00;
      wdata <= RST_ZERO;
      wstrb <= 4'h0;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= RESP_OKAY;
    end
    else
    begin
      if (AXI_AWVALID_I && AXI_AWREADY_O)
      begin
        aw_ok <= 1'b1;
        AXI_AWREADY_O <= 1'b0;
        awaddr <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && AXI_WREADY_O)
      begin
        w_ok <= 1'b1;
        AXI_WREADY_O <= 1'b0;
        wdata <= AXI_WDATA_I;
        wstrb <= AXI_WSTRB_I;
      end
      if (wr_go)
      begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        AXI_AWREADY_O <= 1'b1;
        AXI_WREADY_O <= 1'b1;
        AXI_BVALID_O <= 1'b1;
        AXI_BRESP_O <= (awaddr[7:2] > A_FBMB[7:2] || awaddr[1:0] != 2'h0) ? RESP_SLV : RESP_OKAY;
      end
      else if (AXI_BREADY_I)
        AXI_BVALID_O <= 1'b0;
    end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
    begin
      offs <= RST_ZERO;
      mode <= RST_ZERO;
      term <= RST_ZERO;
      term4 <= RST_ZERO;
      band <= RST_ZERO;
      slp <= RST_ZERO;
      wake <= RST_ZERO;
      lvl <= RST_ZERO;
      fbmb <= RST_ZERO;
    end
    else if (wr_go)
      case (awaddr)
        A_OFFS:  offs  <= merge(offs, wdata, wstrb);
        A_MODE:  mode  <= merge(mode, wdata, wstrb);
        A_TERM:  term  <= merge(term, wdata, wstrb);
        A_TERM4: term4 <= merge(term4, wdata, wstrb);
        A_BAND:  band  <= merge(band, wdata, wstrb);
        A_SLEEP: slp   <= merge(slp, wdata, wstrb);
        A_WAKE:  wake  <= merge(wake, wdata, wstrb);
        A_LVL:   lvl   <= merge(lvl, wdata, wstrb);
        A_FBMB:  fbmb  <= merge(fbmb, wdata, wstrb);
        default: ;
      endcase

  // Stored setting: software loads it, a clear release overwrites it
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
      flash <= RST_ZERO;
    else if (store_ev)
      flash <= {16'h0000, adj}; // RQ12
    else if (wr_go && awaddr == A_FLASH)
      flash <= merge(flash, wdata, wstrb);

  always_comb
  begin
    case (araddr)
      A_OFFS:  rdata = offs;
      A_MODE:  rdata = mode;
      A_TERM:  rdata = term;
      A_TERM4: rdata = term4;
      A_FLASH: rdata = flash;
      A_BAND:  rdata = band;
      A_SLEEP: rdata = slp;
      A_WAKE:  rdata = wake;
      A_LVL:   rdata = lvl;
      A_FBMB:  rdata = fbmb;
      A_STAT:  rdata = stat;
      A_OUT:   rdata = outw;
      default: rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
    begin
      araddr <= 8'h00;
      AXI_ARREADY_O <= 1'b1;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= RST_ZERO;
      AXI_RRESP_O <= RESP_OKAY;
    end
    else if (AXI_ARVALID_I && AXI_ARREADY_O)
    begin
      araddr <= AXI_ARADDR_I;
      AXI_ARREADY_O <= 1'b0;
    end
    else if (!AXI_ARREADY_O && !AXI_RVALID_O)
    begin
      AXI_RVALID_O <= 1'b1;
      AXI_RDATA_O <= rdata;
      AXI_RRESP_O <= (araddr[7:2] > A_OUT[7:2] || araddr[1:0] != 2'h0) ? RESP_SLV : RESP_OKAY;
    end
    else if (AXI_RVALID_O && AXI_RREADY_I)
    begin
      AXI_RVALID_O <= 1'b0;
      AXI_ARREADY_O <= 1'b1;
    end

  // ----------------------------------------
  // Terminal function decode
  // ----------------------------------------
  logic [39:0] tsel;
  logic [4:0]  t_add, t_up, t_dn, t_udc, t_set, t_pdis;
  assign tsel = {term4[7:0], term};
  for (genvar t = 0; t < 5; t++)
  begin : g_term
    assign t_add[t]  = TERM_I[t] && tsel[8*t +: 8] == FN_ADD;    // RQ3
    assign t_up[t]   = TERM_I[t] && tsel[8*t +: 8] == FN_UP;     // RQ6
    assign t_dn[t]   = TERM_I[t] && tsel[8*t +: 8] == FN_DOWN;   // RQ6
    assign t_udc[t]  = TERM_I[t] && tsel[8*t +: 8] == FN_UDC;    // RQ7
    assign t_set[t]  = TERM_I[t] && tsel[8*t +: 8] == FN_SET;    // RQ10
    assign t_pdis[t] = TERM_I[t] && tsel[8*t +: 8] == FN_PIDDIS; // RQ16
  end

  logic add_on, up_on, dn_on, udc_on, set_on, pid_act, ud_eff, udc_q;
  logic [7:0] src, pidm, fbs;
  assign add_on = |t_add;
  assign up_on  = |t_up;
  assign dn_on  = |t_dn;
  assign udc_on = |t_udc;
  assign set_on = |t_set;
  assign src  = mode[M_SRC +: 8];
  assign pidm = mode[M_PID +: 8];
  assign fbs  = mode[M_FB +: 8];
  assign pid_act = (pidm == PID_ON || pidm == PID_INV) && !(|t_pdis); // RQ15 RQ16
  assign ud_eff = !JOG_I && (src == SRC_OPER || (src == SRC_TERM && mode[M_AHD])); // RQ8 RQ9

  // ----------------------------------------
  // Remote raise and lower
  // ----------------------------------------
  logic [10:0] step_cnt;
  logic [10:0] step_lim;
  assign step_lim = set_on ? 11'(UD_STEP2_CYC - 1) : 11'(UD_STEP1_CYC - 1); // RQ10
  assign store_ev = udc_q && !udc_on;

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
    begin
      adj <= 16'h0000;
      udc_q <= 1'b0;
      step_cnt <= 11'h000;
    end
    else
    begin
      udc_q <= udc_on;
      if (udc_on)
        adj <= mode[M_CLR] ? flash[15:0] : 16'h0000; // RQ12 RQ13
      else if (UNDERVOLT_I && !mode[M_MEM])
        adj <= flash[15:0]; // RQ11
      else if (ud_eff && (up_on ^ dn_on))
      begin
        if (step_cnt >= step_lim)
        begin
          step_cnt <= 11'h000;
          if (up_on && adj < FREQ_MAX)
            adj <= adj + 16'h0001; // RQ6
          else if (dn_on && adj != 16'h0000)
            adj <= adj - 16'h0001; // RQ6
        end
        else
          step_cnt <= step_cnt + 11'h001;
      end
      else
        step_cnt <= 11'h000;
    end

  // ----------------------------------------
  // Offset, PID target and limit
  // ----------------------------------------
  logic signed [18:0] base, sum, tgt, dev, res, lim, bw;
  logic [15:0] fb;
  always_comb
  begin
    base = ud_eff ? 19'(signed'({1'b0, adj})) : 19'(FREQ_CMD_I);
    if (!add_on || pid_act)
      sum = base; // RQ1
    else if (mode[M_DIR])
      sum = base - 19'(signed'({1'b0, offs[15:0]})); // RQ2
    else
      sum = base + 19'(signed'({1'b0, offs[15:0]})); // RQ2
    tgt = 19'(signed'({1'b0, PID_TARGET_I}));
    if (add_on && pid_act)
      tgt = mode[M_DIR] ? tgt - 19'(signed'({1'b0, offs[15:0]})) : tgt + 19'(signed'({1'b0, offs[15:0]})); // RQ5
    case (fbs)
      FB_ANALOG: fb = FB_ANALOG_I; // RQ17
      FB_MODBUS: fb = fbmb[15:0];  // RQ17
      FB_ARITH:  fb = FB_ARITH_I;  // RQ17
      default:   fb = 16'h0000;
    endcase
    dev = tgt - 19'(signed'({1'b0, fb}));
    if (mode[M_INV])
      dev = -dev; // RQ18
    bw = 19'(signed'({1'b0, band[9:0], 3'h0})) + 19'(signed'({1'b0, band[9:0], 1'b0}));
    res = 19'(PID_RESULT_I);
    if (res < 0)
      res = (pidm == PID_INV) ? -res : 19'sh0; // RQ15
    lim = res;
    if (pidm != PID_INV && bw != 0)
    begin
      if (res > tgt + bw)
        lim = tgt + bw; // RQ19
      else if (res < tgt - bw)
        lim = tgt - bw; // RQ19
    end
    if (lim < 0)
      lim = 19'sh0;
  end

  logic [18:0] mag;
  logic        neg;
  assign neg = !pid_act && sum < 0; // RQ4
  assign mag = pid_act ? 19'(lim <<< 2) : (neg ? 19'(-sum) : 19'(sum));

  // ----------------------------------------
  // Sleep control
  // ----------------------------------------
  fcm_sleep_type sl, next_sl;
  logic [31:0] tick;
  logic [7:0]  ticks;
  logic [18:0] sl_thr, wk_thr;
  logic        tdone;
  assign sl_thr = 19'({slp[11:0], 3'h0}) + 19'({slp[11:0], 1'b0});
  assign wk_thr = (19'(wake[15:0]) > sl_thr) ? 19'(wake[15:0]) : sl_thr; // RQ21
  assign tdone = ticks >= slp[SL_DLY +: 8];

  always_comb
  begin
    next_sl = sl;
    case (sl)
      SL_RUN:  if (mag < sl_thr) next_sl = SL_WAIT;
      SL_WAIT: if (mag >= sl_thr) next_sl = SL_RUN; else if (tdone) next_sl = SL_OFF; // RQ20
      SL_OFF:  if (mag > wk_thr) next_sl = SL_WAKE;
      SL_WAKE: if (mag <= wk_thr) next_sl = SL_OFF; else if (tdone) next_sl = SL_RUN; // RQ21
      default: next_sl = SL_RUN;
    endcase
  end

  // Delay counted in 0.1 s ticks so the long count stays a parameter
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
    begin
      sl <= SL_RUN;
      tick <= RST_ZERO;
      ticks <= 8'h00;
    end
    else
    begin
      sl <= next_sl;
      if (next_sl != sl || sl == SL_RUN || sl == SL_OFF)
      begin
        tick <= RST_ZERO;
        ticks <= 8'h00;
      end
      else if (tick >= 32'(SLEEP_TICK - 1))
      begin
        tick <= RST_ZERO;
        ticks <= ticks + 8'h01;
      end
      else
        tick <= tick + 32'h0000_0001;
    end

  // ----------------------------------------
  // Flags and outputs
  // ----------------------------------------
  logic [18:0] adev, dlv, fon, foff;
  assign adev = dev < 0 ? 19'(-dev) : 19'(dev);
  assign dlv  = 19'({lvl[9:0], 3'h0}) + 19'({lvl[9:0], 1'b0});
  assign foff = 19'({lvl[LV_OFF +: 10], 3'h0}) + 19'({lvl[LV_OFF +: 10], 1'b0});
  assign fon  = 19'({lvl[LV_ON +: 10], 3'h0}) + 19'({lvl[LV_ON +: 10], 1'b0});
  assign stat = {24'h000000, dev < 0, pid_act, RAMP2_O, FBV_FLAG_O, DEV_FLAG_O, SLEEP_O, REVERSE_O, UD_ACTIVE_O}; // RQ18
  assign outw = {15'h0000, FREQ_O};

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
    if (!rst_n)
    begin
      FREQ_O <= 17'h00000;
      REVERSE_O <= 1'b0;
      RAMP2_O <= 1'b0;
      UD_ACTIVE_O <= 1'b0;
      SLEEP_O <= 1'b0;
      DEV_FLAG_O <= 1'b0;
      FBV_FLAG_O <= 1'b0;
      PID_ACTIVE_O <= 1'b0;
    end
    else
    begin
      FREQ_O <= (sl == SL_OFF || sl == SL_WAKE) ? 17'h00000 : mag[16:0]; // RQ20
      REVERSE_O <= neg; // RQ4
      UD_ACTIVE_O <= ud_eff && (up_on ^ dn_on);
      RAMP2_O <= set_on; // RQ10
      SLEEP_O <= sl == SL_OFF || sl == SL_WAKE;
      PID_ACTIVE_O <= pid_act;
      DEV_FLAG_O <= pid_act && adev > dlv; // RQ22
      if (19'(fb) > fon)
        FBV_FLAG_O <= 1'b1; // RQ22
      else if (19'(fb) < foff)
        FBV_FLAG_O <= 1'b0; // RQ22
    end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!rst_n);
  property p_pass;
    !add_on && !pid_act && sl == SL_RUN && next_sl == SL_RUN |=> FREQ_O == 17'($past(neg) ? -$past(base) : $past(base));
  endproperty
  a_pass: assert property (p_pass) else $error("command not passed"); // RQ1
  property p_sub;
    add_on && !pid_act && mode[M_DIR] |-> sum == base - 19'(offs[15:0]);
  endproperty
  a_sub: assert property (p_sub) else $error("offset subtract wrong"); // RQ2
  property p_rev;
    !pid_act && sum < 0 |=> REVERSE_O;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse missing"); // RQ4
  property p_jog;
    JOG_I && !udc_on && !UNDERVOLT_I |=> adj == $past(adj);
  endproperty
  a_jog: assert property (p_jog) else $error("jog changed setting"); // RQ9
  property p_clr;
    udc_on && !mode[M_CLR] |=> adj == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear not zero"); // RQ13
  property p_pdis;
    (|t_pdis) |=> !PID_ACTIVE_O;
  endproperty
  a_pdis: assert property (p_pdis) else $error("pid not disabled"); // RQ16
  property p_sleep;
    SLEEP_O |-> FREQ_O == 17'h00000 ##1 (SLEEP_O || $past(sl, 2) == SL_WAKE);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep output wrong"); // RQ20
  property p_band;
    pid_act && pidm == PID_ON && bw != 0 && tgt + bw >= 0 |-> lim <= tgt + bw;
  endproperty
  a_band: assert property (p_band) else $error("band exceeded"); // RQ19
  c_add: cover property (add_on && mode[M_DIR] ##1 REVERSE_O);
  c_up: cover property (UD_ACTIVE_O [*3] ##1 adj != 16'h0000);
  c_sleep: cover property (sl == SL_WAIT ##1 sl == SL_OFF);
  c_dev: cover property (DEV_FLAG_O && FBV_FLAG_O);
endmodule

//--- tb/fcm_term_ctl.sv
`timescale 1ns/1ns
module fcm_term_ctl
(
  input  wire logic       clk_i,
  input  wire logic       power_ok_i,
  input  wire logic [4:0] want_i,
  output logic [4:0]      term_o
);
  initial term_o = 5'h00;
  // ------------------------------------------
  // Terminal levels from the external controller
  // ------------------------------------------
  // Levels freeze once power is gone, so a stored setting is never disturbed
  always @(posedge clk_i)
  begin
    if (power_ok_i)
      term_o <= want_i;
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  import fcm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, jog = 1'b0, uv = 1'b0, pwr = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rev, ramp2, udact, slp, devf, feedback_compare_flag, pida;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [4:0] want = 5'h00, term;
  logic signed [17:0] fcmd = 18'sh0, pres = 18'sh0;
  logic [15:0] tgt = 16'h0, fba = 16'h0, fbr = 16'h0;
  logic [16:0] freq;
  logic [7:0] fbs [3] = '{FB_ANALOG, FB_MODBUS, FB_ARITH};
  logic [31:0] gm [5] = '{32'h0, 32'h1, 32'h0800_0001, 32'h2, 32'h2};
  int gj [5] = '{0, 0, 0, 0, 1};
  int ge [5] = '{0, 0, 1, 1, 0};
  int pm [5] = '{1, 1, 1, 2, 2};
  int pr [5] = '{8000, 8000, -1000, -1000, 8000};
  int po [5] = '{0, 1, 0, 0, 0};
  int fv [4] = '{7000, 5000, 3000, 5000};
  int fe [4] = '{1, 1, 0, 0};
  int seed = 32'h7c95;
  int n_fail = 0, checked = 0, c, o, r;

  always #50 clk = ~clk;

  fcm_term_ctl u_fcm_term_ctl (.clk_i(clk), .power_ok_i(pwr), .want_i(want), .term_o(term));
  fcm_top #(.SLEEP_TICK(4)) u_fcm_top (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
    .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hf), .AXI_WVALID_I(wvalid),
    .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
    .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .TERM_I(term),
    .FREQ_CMD_I(fcmd), .JOG_I(jog), .UNDERVOLT_I(uv), .PID_TARGET_I(tgt), .PID_RESULT_I(pres),
    .FB_ANALOG_I(fba), .FB_ARITH_I(fbr), .FREQ_O(freq), .REVERSE_O(rev), .RAMP2_O(ramp2),
    .UD_ACTIVE_O(udact), .SLEEP_O(slp), .DEV_FLAG_O(devf), .FBV_FLAG_O(feedback_compare_flag), .PID_ACTIVE_O(pida));

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ready lines stay high between transfers, so no double drive at the hand-over edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", e, rdata);
  endtask

  // Waits for one step, then times the next one exactly
  task automatic step(input int per, input int d);
    int n, v;
    n = 0;
    v = freq;
    while (freq == v && n < 2100)
    begin
      tick(1);
      n++;
    end
    v = freq;
    tick(per - 1);
    chk("hold", 32'(v), 32'(freq));
    tick(1);
    chk("step", 32'(v + d), 32'(freq));
  endtask

  // Reference for the PID output path, 0.01 percent in, 0.01 Hz out
  function automatic int pexp(int m, int rr, int t, int b);
    int v;
    v = rr;
    if (m == 1 && b != 0)
      v = (v > t + 10 * b) ? t + 10 * b : (v < t - 10 * b) ? t - 10 * b : v;
    v = (v < 0) ? ((m == 2) ? -v : 0) : v;
    return 4 * v;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    tick(50000);
    n_fail++;
    summarize();
  end

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial
  begin
    tick(4);
    rst_n <= 1'b1;
    tick(4);
    chk("freq", 0, 32'(freq));
    rd(A_MODE, 32'h0, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLV);
    rd(8'h05, 32'h0, RESP_SLV);
    wr(8'h30, 32'h1, RESP_SLV);
    for (int t = 0; t < 5; t++)
    begin
      wr(A_TERM, (t < 4) ? (32'(FN_ADD) << (8 * t)) : 32'h0, RESP_OKAY);
      wr(A_TERM4, (t == 4) ? 32'(FN_ADD) : 32'h0, RESP_OKAY);
      for (int k = 0; k < 4; k++)
      begin
        c = $random(seed) % 20000;
        o = {$random(seed)} % 20001;
        wr(A_OFFS, 32'(o), RESP_OKAY);
        wr(A_MODE, 32'(k % 2) << M_DIR, RESP_OKAY);
        fcmd <= 18'(c);
        want <= (k > 1) ? (5'h01 << t) : 5'h00;
        tick(4);
        r = c + ((k > 1) ? ((k % 2) ? -o : o) : 0);
        chk("freq", 32'((r < 0) ? -r : r), 32'(freq));
        chk("reverse", 32'(r < 0), 32'(rev));
      end
    end
    fcmd <= 18'sh0;
    want <= 5'h00;
    wr(A_TERM, {FN_SET, FN_UDC, FN_DOWN, FN_UP}, RESP_OKAY);
    wr(A_TERM4, 32'h0, RESP_OKAY);
    for (int g = 0; g < 5; g++)
    begin
      wr(A_MODE, gm[g], RESP_OKAY);
      jog <= 1'(gj[g]);
      want <= 5'h01;
      tick(4);
      chk("udactive", 32'(ge[g]), 32'(udact));
    end
    jog <= 1'b0;
    want <= 5'h04;
    tick(4);
    chk("clear", 0, 32'(freq));
    want <= 5'h01;
    step(1000, 1);
    want <= 5'h0a;
    tick(4);
    chk("ramp2", 1, 32'(ramp2));
    step(2000, -1);
    wr(A_FLASH, 32'h4d2, RESP_OKAY);
    wr(A_MODE, 32'h2 | (32'h1 << M_CLR), RESP_OKAY);
    want <= 5'h04;
    tick(4);
    chk("clear", 32'h4d2, 32'(freq));
    pwr <= 1'b0;
    want <= 5'h01;
    tick(1100);
    chk("frozen", 32'h4d2, 32'(freq));
    pwr <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      wr(A_MODE, 32'h2 | (32'h1 << M_CLR) | (32'(m) << M_MEM), RESP_OKAY);
      want <= 5'h01;
      step(1000, 1);
      want <= 5'h00;
      uv <= 1'b1;
      tick(4);
      chk("memory", m ? 32'h4d4 : 32'h4d2, 32'(freq));
      uv <= 1'b0;
    end
    wr(A_BAND, 32'h64, RESP_OKAY);
    wr(A_OFFS, 32'h1f4, RESP_OKAY);
    wr(A_TERM, {FN_PIDDIS, FN_UDC, FN_DOWN, FN_UP}, RESP_OKAY);
    wr(A_TERM4, 32'(FN_ADD), RESP_OKAY);
    wr(A_LVL, 32'h64 | (32'h190 << LV_OFF) | (32'h258 << LV_ON), RESP_OKAY);
    tgt <= 16'h1388;
    fba <= 16'h1388;
    fbr <= 16'h1388;
    for (int i = 0; i < 5; i++)
    begin
      wr(A_MODE, (32'(pm[i]) << M_PID) | (32'(FB_ANALOG) << M_FB), RESP_OKAY);
      pres <= 18'(pr[i]);
      want <= po[i] ? 5'h10 : 5'h00;
      tick(4);
      chk("pidfreq", 32'(pexp(pm[i], pr[i], 5000 + 500 * po[i], 100)), 32'(freq));
      chk("pidactive", 1, 32'(pida));
    end
    want <= 5'h08;
    tick(4);
    chk("pidactive", 0, 32'(pida));
    want <= 5'h00;
    for (int s = 0; s < 3; s++)
    begin
      wr(A_MODE, (32'(PID_ON) << M_PID) | (32'(fbs[s]) << M_FB), RESP_OKAY);
      wr(A_FBMB, (s == 1) ? 32'hbb8 : 32'h1388, RESP_OKAY);
      fba <= (s == 0) ? 16'hbb8 : 16'h1388;
      fbr <= (s == 2) ? 16'hbb8 : 16'h1388;
      tick(4);
      chk("devflag", 1, 32'(devf));
    end
    rd(A_STAT, 32'h48, RESP_OKAY);
    wr(A_MODE, (32'(PID_ON) << M_PID) | (32'(FB_ARITH) << M_FB) | (32'h1 << M_INV), RESP_OKAY);
    rd(A_STAT, 32'hc8, RESP_OKAY);
    wr(A_MODE, (32'(PID_ON) << M_PID) | (32'(FB_ANALOG) << M_FB), RESP_OKAY);
    for (int f = 0; f < 4; f++)
    begin
      fba <= 16'(fv[f]);
      tick(4);
      chk("fbvflag", 32'(fe[f]), 32'(feedback_compare_flag));
    end
    chk("devflag", 0, 32'(devf));
    wr(A_MODE, 32'h0, RESP_OKAY);
    tick(4);
    chk("pidactive", 0, 32'(pida));
    fcmd <= 18'sh3e8;
    wr(A_WAKE, 32'hbb8, RESP_OKAY);
    wr(A_SLEEP, 32'hc8 | (32'h5 << SL_DLY), RESP_OKAY);
    tick(10);
    chk("sleep", 0, 32'(slp));
    tick(20);
    chk("sleep", 1, 32'(slp));
    chk("freq", 0, 32'(freq));
    rd(A_STAT, 32'h4, RESP_OKAY);
    fcmd <= 18'sh9c4;
    tick(40);
    chk("sleep", 1, 32'(slp));
    fcmd <= 18'shdac;
    tick(10);
    chk("sleep", 1, 32'(slp));
    tick(20);
    chk("sleep", 0, 32'(slp));
    rd(A_OUT, 32'hdac, RESP_OKAY);
    summarize();
  end
endmodule
